// File: design/vso_top.sv
// Scroll, blink, timing offset and channel gating for a test pattern output path
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
module vso_top #(
  parameter int FAST_CYCLES = vso_pkg::FAST_CYC,
  parameter int SLOW_CYCLES = vso_pkg::SLOW_CYC
) (
  input wire logic REF_CLK_IN,                  // Sample clock
  input wire logic RESETN_IN,                   // Async reset, active low
  input wire logic CE_IN,                       // Clock enable, freezes state when low
  input wire logic HSEL_IN,                     // AHB select
  input wire logic [31:0] HADDR_IN,             // AHB address
  input wire logic [1:0] HTRANS_IN,             // AHB transfer type
  input wire logic HWRITE_IN,                   // AHB write
  input wire logic [2:0] HSIZE_IN,              // AHB size
  input wire logic [31:0] HWDATA_IN,            // AHB write data
  input wire logic HREADY_IN,                   // AHB ready in
  output logic [31:0] HRDATA_OUT,               // AHB read data
  output logic HREADYOUT_OUT,                   // AHB ready out
  output logic HRESP_OUT,                       // AHB response, always OKAY
  input wire logic FRAME_RST_IN,                // Frame reset reference pin
  input wire logic [29:0] CH_DATA_IN,           // Three 10-bit channel samples
  output logic [29:0] CH_DATA_OUT,              // Gated channel samples
  output logic [11:0] H_POS_OUT,                // Output sample position
  output logic [11:0] V_POS_OUT,                // Output line position
  output logic ACTIVE_OUT,                      // Active picture flag
  output logic [11:0] SRC_X_OUT,                // Scrolled picture column
  output logic [11:0] SRC_Y_OUT,                // Scrolled picture row
  output logic OVL_SHOW_OUT,                    // Overlay visible now
  output vso_pkg::vso_kind_t OVL_KIND_OUT       // Selected overlay kind
);
  import vso_pkg::*;

  logic signed [7:0] hstep_q;
  logic signed [4:0] vstep_q;
  logic [4:0] period_q;
  logic rand_q;
  vso_kind_t kind_q;
  vso_blink_t blink_q;
  logic ovl_en_q;
  logic signed [15:0] hoff_q;
  logic signed [15:0] voff_q;
  logic [2:0] chan_q;
  logic pend_q;
  logic pend_wr_q;
  logic [7:0] pend_addr_q;
  logic [2:0] sync_q;
  logic lvl_q;
  logic frame_ev;
  logic [11:0] h_q;
  logic [11:0] v_q;
  logic frame_tick;
  logic [4:0] fcnt_q;
  logic scroll_ev;
  logic [15:0] lfsr_q;
  logic signed [7:0] rnd_h;
  logic signed [4:0] rnd_v;
  logic signed [7:0] step_h;
  logic signed [4:0] step_v;
  logic [11:0] disp_h_q;
  logic [11:0] disp_v_q;
  logic [31:0] bcnt_q;
  logic phase_q;
  logic [31:0] blink_lim;
  logic act;

  function automatic logic [11:0] wrap(input logic signed [13:0] x, input logic [11:0] n);
    logic signed [13:0] m;
    m = $signed({2'b00, n});
    if (x < 14'sh0) begin
      wrap = 12'(x + m);
    end else if (x >= m) begin
      wrap = 12'(x - m);
    end else begin
      wrap = 12'(x);
    end
  endfunction : wrap

  function automatic logic signed [15:0] clamp(input logic signed [15:0] x,
                                               input logic signed [15:0] lim);
    if (x > lim) begin
      clamp = lim;
    end else if (x < -lim) begin
      clamp = -lim;
    end else begin
      clamp = x;
    end
  endfunction : clamp

  // AHB-Lite slave: zero wait states; the whole bus stalls while the clock enable is low
  assign HREADYOUT_OUT = CE_IN;
  assign HRESP_OUT = 1'b0;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pend_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_addr_q <= 8'h00;
    end else if (CE_IN) begin
      pend_q <= HSEL_IN & HREADY_IN & HTRANS_IN[1] & (HSIZE_IN == 3'h2);
      pend_wr_q <= HWRITE_IN;
      pend_addr_q <= HADDR_IN[7:0];
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      HRDATA_OUT <= 32'h0;
    end else if (CE_IN) begin
      HRDATA_OUT <= 32'h0;
      if (HSEL_IN & HREADY_IN & HTRANS_IN[1] & ~HWRITE_IN) begin
        if (HADDR_IN[7:0] == A_SCROLL) begin
          HRDATA_OUT <= {7'h0, rand_q, 3'h0, period_q, 3'h0, vstep_q, hstep_q};
        end else if (HADDR_IN[7:0] == A_OVERLAY) begin
          HRDATA_OUT <= {23'h0, ovl_en_q, 2'h0, blink_q, 1'b0, kind_q};
        end else if (HADDR_IN[7:0] == A_TIMING) begin
          HRDATA_OUT <= {voff_q, hoff_q};
        end else if (HADDR_IN[7:0] == A_CHAN) begin
          HRDATA_OUT <= {29'h0, chan_q};
        end else if (HADDR_IN[7:0] == A_STATUS) begin
          HRDATA_OUT <= {3'h0, phase_q, disp_v_q, 4'h0, disp_h_q};
        end
      end
    end
  end

  // Scroll and timing writes are clamped into the legal ranges; illegal overlay kind and blink values are ignored
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      hstep_q <= 8'sh0;
      vstep_q <= 5'sh0;
      period_q <= PERIOD_RST;
      rand_q <= 1'b0;
      kind_q <= VSO_LOGO;
      blink_q <= VSO_BLINK_OFF;
      ovl_en_q <= 1'b0;
      hoff_q <= 16'sh0;
      voff_q <= 16'sh0;
      chan_q <= CHAN_RST;
    end else if (CE_IN && pend_q && pend_wr_q) begin
      if (pend_addr_q == A_SCROLL) begin
        hstep_q <= 8'(clamp(16'(signed'(HWDATA_IN[7:0])), 16'(HSTEP_MAX)) & ~16'sh3);
        vstep_q <= 5'(clamp(16'(signed'(HWDATA_IN[F_VSTEP+:5])), 16'(VSTEP_MAX)));
        if (HWDATA_IN[F_PERIOD+:5] < 5'(PERIOD_MIN)) begin
          period_q <= 5'(PERIOD_MIN);
        end else if (HWDATA_IN[F_PERIOD+:5] > 5'(PERIOD_MAX)) begin
          period_q <= 5'(PERIOD_MAX);
        end else begin
          period_q <= HWDATA_IN[F_PERIOD+:5];
        end
        rand_q <= HWDATA_IN[F_RANDOM];
      end else if (pend_addr_q == A_OVERLAY) begin
        if ($onehot(HWDATA_IN[2:0])) begin
          kind_q <= vso_kind_t'(HWDATA_IN[2:0]);
        end
        if (HWDATA_IN[F_BLINK+:2] != 2'h3) begin
          blink_q <= vso_blink_t'(HWDATA_IN[F_BLINK+:2]);
        end
        ovl_en_q <= HWDATA_IN[F_OVL_EN];
      end else if (pend_addr_q == A_TIMING) begin
        hoff_q <= clamp(signed'(HWDATA_IN[15:0]), 16'(H_TOTAL));
        voff_q <= clamp(signed'(HWDATA_IN[F_VOFF+:16]), 16'(V_TOTAL));
      end else if (pend_addr_q == A_CHAN) begin
        chan_q <= HWDATA_IN[2:0];
      end
    end
  end

  // Frame reset pin: three stages, a rise counts once stages two and three agree
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync_q <= 3'h0;
      lvl_q <= 1'b0;
    end else if (CE_IN) begin
      sync_q <= {sync_q[1:0], FRAME_RST_IN};
      if (sync_q[1] == sync_q[2]) begin
        lvl_q <= sync_q[2];
      end
    end
  end
  assign frame_ev = (sync_q[1] == sync_q[2]) & sync_q[2] & ~lvl_q;

  // Output counters realign on each reference so that output lags it by the offset
  logic signed [13:0] hs;
  logic [11:0] h_start;
  logic signed [13:0] v_start_raw;
  assign hs = -14'(hoff_q);
  assign h_start = wrap(hs, 12'(H_TOTAL));
  assign v_start_raw = -14'(voff_q)
                     + ((hs < 14'sh0) ? -14'sh1 : (hs >= 14'(H_TOTAL)) ? 14'sh1 : 14'sh0);
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      h_q <= 12'h0;
      v_q <= 12'h0;
    end else if (CE_IN) begin
      if (frame_ev) begin
        h_q <= h_start;
        v_q <= wrap(v_start_raw, 12'(V_TOTAL));
      end else if (h_q == 12'(H_TOTAL - 1)) begin
        h_q <= 12'h0;
        v_q <= (v_q == 12'(V_TOTAL - 1)) ? 12'h0 : v_q + 12'h1;
      end else begin
        h_q <= h_q + 12'h1;
      end
    end
  end
  assign frame_tick = ~frame_ev & (h_q == 12'(H_TOTAL - 1)) & (v_q == 12'(V_TOTAL - 1));

  // Scroll period counter
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      fcnt_q <= 5'h0;
    end else if (CE_IN && frame_tick) begin
      fcnt_q <= scroll_ev ? 5'h0 : fcnt_q + 5'h1;
    end
  end
  assign scroll_ev = frame_tick & (fcnt_q + 5'h1 >= period_q);

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lfsr_q <= 16'hACE1;
    end else if (CE_IN) begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end
  assign rnd_h = 8'(clamp(16'(signed'({lfsr_q[4:0], 2'b00})), 16'(HSTEP_MAX)));
  assign rnd_v = 5'(clamp(16'(signed'(lfsr_q[12:8])), 16'(VSTEP_MAX)));
  assign step_h = rand_q ? rnd_h : hstep_q;
  assign step_v = rand_q ? rnd_v : vstep_q;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      disp_h_q <= 12'h0;
      disp_v_q <= 12'h0;
    end else if (CE_IN && scroll_ev) begin
      disp_h_q <= wrap(14'(disp_h_q) + 14'(step_h), 12'(ACT_W));
      disp_v_q <= wrap(14'(disp_v_q) + 14'(step_v), 12'(ACT_H));
    end
  end

  // Picture coordinates and gated channel data
  assign act = (h_q >= 12'(H_ACT_START)) & (h_q < 12'(H_ACT_START + ACT_W))
             & (v_q >= 12'(V_ACT_START)) & (v_q < 12'(V_ACT_START + ACT_H));

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      H_POS_OUT <= 12'h0;
      V_POS_OUT <= 12'h0;
      ACTIVE_OUT <= 1'b0;
      SRC_X_OUT <= 12'h0;
      SRC_Y_OUT <= 12'h0;
      CH_DATA_OUT <= 30'h0;
    end else if (CE_IN) begin
      H_POS_OUT <= h_q;
      V_POS_OUT <= v_q;
      ACTIVE_OUT <= act;
      if (act) begin
        SRC_X_OUT <= wrap(14'(h_q) - 14'(H_ACT_START) - 14'(disp_h_q), 12'(ACT_W));
        SRC_Y_OUT <= wrap(14'(v_q) - 14'(V_ACT_START) - 14'(disp_v_q), 12'(ACT_H));
      end else begin
        SRC_X_OUT <= h_q;
        SRC_Y_OUT <= v_q;
      end
      for (int i = 0; i < 3; i++) begin
        CH_DATA_OUT[i*10+:10] <= chan_q[i] ? CH_DATA_IN[i*10+:10] : 10'h0;
      end
    end
  end

  // Blink timer
  assign blink_lim = (blink_q == VSO_BLINK_FAST) ? 32'(FAST_CYCLES - 1) : 32'(SLOW_CYCLES - 1);

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      bcnt_q <= 32'h0;
      phase_q <= 1'b1;
    end else if (CE_IN) begin
      if (blink_q == VSO_BLINK_OFF) begin
        bcnt_q <= 32'h0;
        phase_q <= 1'b1;
      end else if (bcnt_q >= blink_lim) begin
        bcnt_q <= 32'h0;
        phase_q <= ~phase_q;
      end else begin
        bcnt_q <= bcnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      OVL_SHOW_OUT <= 1'b0;
      OVL_KIND_OUT <= VSO_LOGO;
    end else if (CE_IN) begin
      OVL_SHOW_OUT <= ovl_en_q & phase_q;
      OVL_KIND_OUT <= kind_q;
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_hstep_legal: assert property (hstep_q <= 8'sd60 && hstep_q >= -8'sd60
    && hstep_q[1:0] == 2'b00)
    else $error("hstep out of range");
  a_vstep_legal: assert property (vstep_q <= 5'sd15 && vstep_q >= -5'sd15)
    else $error("vstep out of range");
  a_scroll_period: assert property (scroll_ev
    |-> fcnt_q == period_q - 5'h1 || fcnt_q >= period_q)
    else $error("scroll event off period");
  a_disp_hold: assert property (CE_IN && !scroll_ev |=> $stable({disp_h_q, disp_v_q}))
    else $error("displacement moved without event");
  a_disp_step: assert property (CE_IN && scroll_ev && !rand_q && hstep_q == 8'sd4
    && disp_h_q < 12'd700 |=> disp_h_q == $past(disp_h_q) + 12'd4)
    else $error("displacement not advanced by step");
  a_blank_plain: assert property (!ACTIVE_OUT |-> SRC_X_OUT == H_POS_OUT
    && SRC_Y_OUT == V_POS_OUT)
    else $error("blanking coordinates scrolled");
  a_rand_bound: assert property (rnd_h <= 8'sd60 && rnd_h >= -8'sd60 && rnd_v <= 5'sd15
    && rnd_v >= -5'sd15)
    else $error("random step out of range");
  a_rand_select: assert property (rand_q |-> step_h == rnd_h && step_v == rnd_v)
    else $error("random step not used");
  a_blink_steady: assert property ((CE_IN && blink_q == VSO_BLINK_OFF)
    ##1 (CE_IN && blink_q == VSO_BLINK_OFF && ovl_en_q) |=> OVL_SHOW_OUT)
    else $error("overlay not steady");
  a_kind_onehot: assert property ($onehot(OVL_KIND_OUT))
    else $error("overlay kind not one-hot");
  a_frame_align: assert property (CE_IN && frame_ev && hoff_q == 16'sh0 && voff_q == 16'sh0
    |=> h_q == 12'h0 && v_q == 12'h0)
    else $error("frame not aligned to reference");
  a_chan_gate: assert property (CE_IN && !chan_q[0] |=> CH_DATA_OUT[9:0] == 10'h0)
    else $error("disabled channel carries data");
  a_offset_range: assert property (hoff_q <= 16'sd858 && hoff_q >= -16'sd858
    && voff_q <= 16'sd525 && voff_q >= -16'sd525)
    else $error("timing offset out of range");
  c_scroll: cover property (scroll_ev && !rand_q);
  c_rand_scroll: cover property (scroll_ev && rand_q);
  c_blink_toggle: cover property (blink_q != VSO_BLINK_OFF && $changed(phase_q));
  c_write: cover property (CE_IN && pend_q && pend_wr_q);
endmodule : vso_top

// File: design/vso_pkg.sv
// Constants, register map and field layout for the scroll and overlay control block
// Operation
// - The horizontal scroll step is signed, from -60 to +60 samples, in steps of four.
// - The vertical scroll step is signed, from -15 to +15 lines, in steps of one.
// - The scroll period is 1 to 16 frames and one scroll event occurs per elapsed period.
// - Each scroll event adds the horizontal and vertical steps to the picture displacement.
// - Scrolling moves only the active picture and leaves blanking and sync untouched.
// - With random scroll on the displacement moves by random steps, otherwise by the steps.
// - Blink off shows the overlay steadily, fast toggles every 0.5 s, slow every 1.0 s.
// - Exactly one overlay kind is chosen at a time: logo, identification text or circle.
// - Output timing is shifted by a programmable offset against the frame reset reference.
// - Each of the three output channels has its own enable and a disabled one carries nothing.
// - The horizontal offset spans minus one to plus one line in steps of one sample clock.
// - The vertical offset spans minus one to plus one frame in steps of one line.
package vso_pkg;
  localparam int CLK_KHZ = 125000;
  localparam int FAST_MS = 500;
  localparam int SLOW_MS = 1000;
  localparam int FAST_CYC = FAST_MS * CLK_KHZ;
  localparam int SLOW_CYC = SLOW_MS * CLK_KHZ;
  localparam int H_TOTAL = 858;
  localparam int V_TOTAL = 525;
  localparam int H_ACT_START = 138;
  localparam int V_ACT_START = 39;
  localparam int ACT_W = 720;
  localparam int ACT_H = 486;
  localparam int HSTEP_MAX = 60;
  localparam int VSTEP_MAX = 15;
  localparam int PERIOD_MIN = 1;
  localparam int PERIOD_MAX = 16;
  localparam logic [7:0] A_SCROLL = 8'h00;
  localparam logic [7:0] A_OVERLAY = 8'h04;
  localparam logic [7:0] A_TIMING = 8'h08;
  localparam logic [7:0] A_CHAN = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam int F_VSTEP = 8;
  localparam int F_PERIOD = 16;
  localparam int F_RANDOM = 24;
  localparam int F_BLINK = 4;
  localparam int F_OVL_EN = 8;
  localparam int F_VOFF = 16;
  localparam logic [4:0] PERIOD_RST = 5'h01;
  localparam logic [2:0] CHAN_RST = 3'h7;
  typedef enum logic [2:0] {
    VSO_LOGO = 3'b001,
    VSO_TEXT = 3'b010,
    VSO_CIRCLE = 3'b100
  } vso_kind_t;
  typedef enum logic [1:0] {
    VSO_BLINK_OFF = 2'h0,
    VSO_BLINK_FAST = 2'h1,
    VSO_BLINK_SLOW = 2'h2
  } vso_blink_t;
endpackage : vso_pkg

// File: sim/vso_monitor.sv
// Receiving monitor model: counts frame ends and flags positions outside the raster
module vso_monitor
  import vso_pkg::*;
(
  input wire logic clk_in,           // Sample clock
  input wire logic [11:0] h_pos_in,  // Received sample position
  input wire logic [11:0] v_pos_in,  // Received line position
  output int frames_out,             // Frame ends seen
  output int bad_out                 // Positions outside the raster
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frames_out = 0;
    bad_out = 0;
  end
  always @(posedge clk_in) begin
    if (h_pos_in == H_TOTAL - 1 && v_pos_in == V_TOTAL - 1) begin
      frames_out <= frames_out + 1;
    end
    if (h_pos_in >= H_TOTAL || v_pos_in >= V_TOTAL) begin
      bad_out <= bad_out + 1;
    end
  end
endmodule : vso_monitor

// File: sim/vso_top_test.sv
// Self-checking bench for the scroll, blink, offset and channel gating block
module vso_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import vso_pkg::*;
  localparam int FC = 20;
  localparam int SC = 40;
  logic clk = 0, rst_n = 0, ce = 1, fref = 0, hwrite = 0, hrdy, hresp, act, show;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [29:0] chd = 30'h1234_5678, cho;
  logic [11:0] hp, vp, sx, sy;
  vso_kind_t kind;
  int err_total = 0, n_checks = 0, exp_h = 0, exp_v = 0, frames, bad;
  always #4 clk = ~clk;
  vso_top #(.FAST_CYCLES(FC), .SLOW_CYCLES(SC)) u_vso_top (.REF_CLK_IN(clk),
    .RESETN_IN(rst_n), .CE_IN(ce), .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hrdy),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp), .FRAME_RST_IN(fref),
    .CH_DATA_IN(chd), .CH_DATA_OUT(cho), .H_POS_OUT(hp), .V_POS_OUT(vp), .ACTIVE_OUT(act),
    .SRC_X_OUT(sx), .SRC_Y_OUT(sy), .OVL_SHOW_OUT(show), .OVL_KIND_OUT(kind));
  vso_monitor u_vso_monitor (.clk_in(clk), .h_pos_in(hp), .v_pos_in(vp),
    .frames_out(frames), .bad_out(bad));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd ^ {31'h0, hresp}, e);
  endtask : rchk
  task automatic pulse();
    @(posedge clk);
    fref <= 1'b1;
    repeat (8) @(posedge clk);
    fref <= 1'b0;
  endtask : pulse
  // Offset of one line makes the next frame end come one line after the reference
  task automatic frame();
    int f0, n;
    f0 = frames;
    n = 0;
    pulse();
    while (frames == f0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(frames - f0), 32'h1);
    repeat (4) @(posedge clk);
  endtask : frame
  task automatic stat();
    bus(1'b0, A_STATUS, 32'h0);
    chk(rd & 32'h0FFF_0FFF, {4'h0, 12'(exp_v), 4'h0, 12'(exp_h)});
  endtask : stat
  task automatic step(input logic [7:0] h, input logic [4:0] v, input int dh, input int dv);
    bus(1'b1, A_SCROLL, {16'h0001, 3'h0, v, h});
    frame();
    exp_h = (exp_h + dh + 720) % 720;
    exp_v = (exp_v + dv + 486) % 486;
    stat();
  endtask : step
  task automatic t_regs();
    rchk(A_SCROLL, 32'h0001_0000);
    rchk(A_OVERLAY, 32'h0000_0001);
    rchk(A_TIMING, 32'h0);
    rchk(A_CHAN, 32'h0000_0007);
    rchk(A_STATUS, 32'h1000_0000);
    bus(1'b1, A_STATUS, 32'h0000_0FFF);
    rchk(A_STATUS, 32'h1000_0000);
    bus(1'b1, 8'h14, 32'hFFFF_FFFF);
    rchk(8'h14, 32'h0);
    bus(1'b1, A_TIMING, 32'h020D_FCA6);
    rchk(A_TIMING, 32'h020D_FCA6);
    $display("Test regs finished");
  endtask : t_regs
  task automatic t_kind();
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, A_OVERLAY, 32'(1 << k));
      repeat (2) @(negedge clk);
      chk(32'(kind), 32'(1 << k));
    end
    bus(1'b1, A_OVERLAY, 32'h0000_0033);
    rchk(A_OVERLAY, 32'h0000_0004);
    chk(32'(kind), 32'h4);
    $display("Test kind finished");
  endtask : t_kind
  task automatic t_chan();
    for (int e = 0; e < 8; e++) begin
      bus(1'b1, A_CHAN, 32'(e));
      repeat (3) @(negedge clk);
      chk(32'(cho), 32'(chd & {{10{e[2]}}, {10{e[1]}}, {10{e[0]}}}));
    end
    $display("Test chan finished");
  endtask : t_chan
  // Clock enable low freezes the counters and stalls the bus
  task automatic t_hold();
    logic [11:0] h0;
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(negedge clk);
    h0 = hp;
    repeat (6) @(negedge clk);
    chk(32'(hp), 32'(h0));
    chk(32'(hrdy), 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(hp !== h0), 32'h1);
    $display("Test hold finished");
  endtask : t_hold
  task automatic blink(input logic [31:0] v, input int per);
    logic s;
    int n;
    bus(1'b1, A_OVERLAY, v);
    repeat (3) @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      s = show;
      n = 0;
      while (show === s && n < 4 * per + 200) begin
        @(negedge clk);
        n++;
      end
    end
    chk(32'(n), 32'(per == 0 ? 200 : per));
  endtask : blink
  task automatic t_blink();
    blink(32'h0000_0101, 0);
    chk(32'(show), 32'h1);
    blink(32'h0000_0111, FC);
    blink(32'h0000_0121, SC);
    bus(1'b1, A_OVERLAY, 32'h0000_0011);
    repeat (3) @(negedge clk);
    chk(32'(show), 32'h0);
    $display("Test blink finished");
  endtask : t_blink
  task automatic t_offset();
    bus(1'b1, A_TIMING, 32'h0);
    pulse();
    repeat (4) @(negedge clk);
    chk(32'(vp), 32'h0);
    chk(32'(hp >= 4 && hp <= 12), 32'h1);
    bus(1'b1, A_TIMING, 32'h0001_0000);
    pulse();
    repeat (4) @(negedge clk);
    chk(32'(vp), 32'(V_TOTAL - 1));
    chk(32'(bad), 32'h0);
    $display("Test offset finished");
  endtask : t_offset
  task automatic t_scroll();
    step(8'h3C, 5'h0F, 60, 15);
    step(8'hC4, 5'h11, -60, -15);
    step(8'h06, 5'h01, 4, 1);
    step(8'h7F, 5'h10, 60, -15);
    step(8'h80, 5'h1D, -60, -3);
    bus(1'b1, A_SCROLL, 32'h0003_0004);
    repeat (3) frame();
    exp_h = (exp_h + 4) % 720;
    stat();
    repeat (3) frame();
    exp_h = (exp_h + 4) % 720;
    stat();
    bus(1'b1, A_SCROLL, 32'h0000_0004);
    frame();
    exp_h = (exp_h + 4) % 720;
    stat();
    $display("Test scroll finished");
  endtask : t_scroll
  // Reference load at line 100 so active lines follow within two lines
  task automatic t_area();
    int x, y, ae, ok;
    bus(1'b1, A_TIMING, 32'hFF9C_0000);
    pulse();
    repeat (1716) begin
      @(negedge clk);
      x = int'(hp) - H_ACT_START;
      y = int'(vp) - V_ACT_START;
      ae = (x >= 0 && y >= 0);
      ok = ae ? (sx === 12'((x + 720 - exp_h) % 720) && sy === 12'((y + 486 - exp_v) % 486))
              : (sx === hp && sy === vp);
      chk(32'(ok && act === ae[0]), 32'h1);
    end
    $display("Test area finished");
  endtask : t_area
  task automatic t_random();
    int oh, ov, dh, dv, moved;
    moved = 0;
    bus(1'b1, A_TIMING, 32'h0001_0000);
    bus(1'b1, A_SCROLL, 32'h0100_0000);
    repeat (4) begin
      bus(1'b0, A_STATUS, 32'h0);
      oh = int'(rd[11:0]);
      ov = int'(rd[27:16]);
      frame();
      bus(1'b0, A_STATUS, 32'h0);
      dh = (int'(rd[11:0]) - oh + 720) % 720;
      dv = (int'(rd[27:16]) - ov + 486) % 486;
      chk(32'(dh % 4 == 0 && (dh <= 60 || dh >= 660)), 32'h1);
      chk(32'(dv <= 15 || dv >= 471), 32'h1);
      moved += (dh != 0 || dv != 0);
    end
    chk(32'(moved > 0), 32'h1);
    $display("Test random finished");
  endtask : t_random
  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #(80000 * 8);
    err_total++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_kind();
    t_chan();
    t_hold();
    t_blink();
    t_offset();
    t_scroll();
    t_area();
    t_random();
    close_out();
  end
endmodule : vso_top_test
